// ===== dv/spd_check_sva.sv
// Purpose: port-level checker for spd_top
// Assumes: sees only the top ports; one clock domain
// Notes:   read data is judged one cycle after its address phase
`timescale 1ns/100ps
module spd_check
	import spd_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire spd_sample_t in_samp,
	input wire spd_sample_t out_samp,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic       rd_ph;	// read address phase taken
	logic [7:0] ra;	// decoded offset
	assign rd_ph = hsel & htrans[1] & hready & ~hwrite;
	assign ra = haddr[7:0];
	// feedback bytes never leave the clamp
	function automatic logic in99(logic [7:0] b);
		return ($signed(b) >= -99) && ($signed(b) <= 99);
	endfunction
	// ************************************************************
	// audio path
	// ************************************************************
	out_follow_a: assert property (in_samp.valid |=> out_samp.valid)
		else $error("output strobe missing after input strobe");
	out_single_a: assert property (out_samp.valid |=> !out_samp.valid)
		else $error("output strobe longer than one cycle");
	out_cause_a: assert property (out_samp.valid |-> $past(in_samp.valid))
		else $error("output strobe without input strobe");
	out_hold_a: assert property (!out_samp.valid |-> $stable(out_samp.left) &&
		$stable(out_samp.right)) else $error("output data moved between strobes");
	// ************************************************************
	// register bus
	// ************************************************************
	rdy_up_a: assert property (!$past(rst) |-> hreadyout)
		else $error("wait state inserted");
	okay_a: assert property (hresp == 1'b0)
		else $error("error response seen");
	unmap_zero_a: assert property (rd_ph && ra > 8'h38 |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	status_bits_a: assert property (rd_ph && ra == 8'h34 |=> hrdata[31:2] == '0)
		else $error("status spare bits set");
	fb_clamp_a: assert property (rd_ph && ra == 8'h14 |=> in99(hrdata[7:0]) &&
		in99(hrdata[15:8]) && in99(hrdata[23:16]) && in99(hrdata[31:24]))
		else $error("feedback gain outside clamp");
	binaural_spreader_max_a: assert property (rd_ph && ra == 8'h28 |=> hrdata <= 32'h0000_000A)
		else $error("spreader setting above ten");
endmodule

// ===== dv/spd_src.sv
// Purpose: upstream audio source feeding spd_top
// Assumes: one strobe every 4 clk, above the 2-clk minimum
// Notes:   data lines alternate between the inverse and the last word between strobes
`timescale 1ns/100ps
module spd_src
	import spd_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire spd_samp_t l_in,
	input  wire spd_samp_t r_in,
	output spd_sample_t    smp
);
	logic [1:0] ph_ff;	// strobe phase counter
	logic       fire;	// strobe due this edge
	assign fire = (ph_ff == 2'h3);
	// stale data is scrambled so nothing leans on it outside the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_ff <= 2'h0;
			smp   <= '0;
		end else begin
			ph_ff     <= ph_ff + 2'h1;
			smp.valid <= fire;
			smp.left  <= fire ? l_in : ~smp.left;
			smp.right <= fire ? r_in : ~smp.right;
		end
	end
endmodule

// ===== dv/testbench.sv
// Purpose: self-checking bench for spd_top
// Assumes: zero-wait register bus, source strobes every 4 clk
// Notes:   small coarse step keeps delay runs short
`timescale 1ns/100ps
`include "spd_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench import spd_pkg::*;;
	localparam int        CS  = 4;	// shortened coarse step
	localparam spd_samp_t IMP = 24'h10_0000;	// test impulse
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] haddr, hwdata, hrdata, rq;
	logic [1:0]  htrans;
	logic        hwrite, hreadyout, hresp;
	spd_samp_t   lv, rv, ol, orr, fl, fr, base, av;
	spd_sample_t in_samp, out_samp;
	int          fail_count, compares, dl, dr, at;
	always #2 clk = ~clk;
	spd_top #(.COARSE_STEP(CS)) u_dut (.clk(clk), .rst(rst), .in_samp(in_samp),
		.out_samp(out_samp), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	spd_src u_src (.clk(clk), .rst(rst), .l_in(lv), .r_in(rv), .smp(in_samp));
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic results();
		if (fail_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// bounded wait on bus ready or the source strobe
	task automatic wait_for(input logic src);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((src ? in_samp.valid : hreadyout) !== 1'b1 && n < 20);
		if ((src ? in_samp.valid : hreadyout) !== 1'b1) begin
			fail_count++;
			results();
		end
	endtask
	// one single word transfer; read data lands in rq
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		htrans <= 2'h2;
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		wait_for(1'b0);
		htrans <= 2'h0;
		hwdata <= d;
		wait_for(1'b0);
		rq = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(rq, e);
	endtask
	// one sample in, the matching output sample out
	task automatic step(input spd_samp_t l, input spd_samp_t r);
		@(posedge clk);
		lv <= l;
		rv <= r;
		wait_for(1'b1);
		@(posedge clk);
		ol = out_samp.left;
		orr = out_samp.right;
	endtask
	// zero priming covers stale memory, then first nonzero index per side
	task automatic meas(input spd_samp_t il, input spd_samp_t ir);
		dl = -1;
		dr = -1;
		for (int i = -512; i < 520; i++) begin
			step((i == 0) ? il : '0, (i == 0) ? ir : '0);
			if (i == at) begin
				av = ol;
			end
			if (i >= 0 && dl < 0 && ol != '0) begin
				dl = i;
				fl = ol;
			end
			if (i >= 0 && dr < 0 && orr != '0) begin
				dr = i;
				fr = orr;
			end
		end
	endtask
	task automatic dly(input int el, input int er);
		meas(IMP, IMP);
		`CHK(dl, el);
		`CHK(dr, er);
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		htrans = 2'h0;
		haddr = '0;
		hwrite = 1'b0;
		hwdata = '0;
		lv = '0;
		rv = '0;
		fail_count = 0;
		compares = 0;
		at = -1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(8'h18, 32'h0800_1000);
		rd(8'h1C, 32'h0800_1000);
		rd(8'h20, 32'h0000_0800);
		rd(8'h24, 32'h1000_1000);
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C, 32'h0000_0000);
		wr(8'h34, 32'h0000_0003);
		rd(8'h34, 32'h0000_0000);
		wr(8'h14, 32'h0000_807F);
		rd(8'h14, 32'h0000_9D63);
		rd(8'h34, 32'h0000_0001);
		wr(8'h14, 32'h0000_3232);
		rd(8'h34, 32'h0000_0000);
		wr(8'h14, 32'h0000_3332);
		rd(8'h34, 32'h0000_0001);
		wr(8'h14, 32'hC429_0000);
		rd(8'h34, 32'h0000_0002);
		wr(8'h14, 32'h0000_0000);
		wr(8'h28, 32'h0000_000F);
		rd(8'h28, 32'h0000_000A);
		wr(8'h28, 32'h0000_0000);
		wr(8'h38, 32'h0000_000F);
		rd(8'h00, 32'h0000_000F);
		wr(8'h38, 32'h0000_000F);
		dly(2, 2);
		base = fl;
		wr(8'h04, 32'h0000_0002);
		dly(2 + 2 * CS, 2 + 2 * CS);
		wr(8'h04, 32'h0000_0000);
		wr(8'h08, 32'h0000_0003);
		wr(8'h0C, 32'h0000_0001);
		dly(2 + 3 * CS, 2 + CS);
		wr(8'h38, 32'h0000_0001);
		dly(2 + 3 * CS / 2, 2 + CS);
		wr(8'h38, 32'h0000_0001);
		wr(8'h08, 32'h0000_0000);
		wr(8'h0C, 32'h0000_0000);
		wr(8'h10, 32'h012C_0005);
		dly(12, 502);
		wr(8'h38, 32'h0000_0004);
		dly(7, 502);
		wr(8'h38, 32'h0000_0004);
		wr(8'h10, 32'h0000_0000);
		wr(8'h14, 32'h0000_0032);
		at = 5;
		meas(IMP, '0);
		`CHK($signed(av) > 24'sh07_F000 && $signed(av) <= 24'sh08_0000, 1'b1);
		wr(8'h14, 32'h0000_3200);
		at = 3;
		meas(IMP, '0);
		`CHK($signed(av) > 24'sh07_F000 && $signed(av) <= 24'sh08_0000, 1'b1);
		wr(8'h14, 32'h0000_0000);
		wr(8'h28, 32'h0000_000A);
		meas(IMP, IMP);
		`CHK(fl, IMP);
		`CHK(fr, IMP);
		meas(IMP, '0);
		`CHK(fr[23], 1'b1);
		wr(8'h28, 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			wr(8'h00, 32'(k << 6));
			meas('0, IMP);
			`CHK(k[1] ? dl : dr, 2);
			`CHK(k[1] ? dr : dl, -1);
			`CHK(k[1] ? fl[23] : fr[23], k[0]);
		end
		wr(8'h00, 32'h0000_0200);
		meas(IMP, IMP);
		`CHK($signed(fl) < $signed(fr), 1'b1);
		wr(8'h00, 32'h0000_0100);
		meas(IMP, '0);
		`CHK(fl != base, 1'b1);
		wr(8'h00, 32'h0000_0010);
		wr(8'h2C, 32'h0000_1000);
		meas('0, '0);
		`CHK(ol != '0, 1'b1);
		wr(8'h00, 32'h0000_0000);
		meas('0, '0);
		`CHK(ol, 24'h00_0000);
		results();
	end
endmodule
bind spd_top spd_check u_chk (.clk(clk), .rst(rst), .in_samp(in_samp),
	.out_samp(out_samp), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata));

// ===== pkg/spd_params.svh
// Purpose: named constants of the stereo post delay / adjust block
// Assumes: 32-bit register bus, 24-bit samples
// Notes:   offsets are byte addresses of word registers
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH
// ************************************************************
// register offsets
// ************************************************************
`define SPD_A_CTRL     8'h00
`define SPD_A_MASTER   8'h04
`define SPD_A_LCOARSE  8'h08
`define SPD_A_RCOARSE  8'h0C
`define SPD_A_FINE     8'h10
`define SPD_A_FBACK    8'h14
`define SPD_A_LOW      8'h18
`define SPD_A_HIGH     8'h1C
`define SPD_A_SPLITC   8'h20
`define SPD_A_SPLITG   8'h24
`define SPD_A_BINAURAL_SPREADER     8'h28
`define SPD_A_DCL      8'h2C
`define SPD_A_DCR      8'h30
`define SPD_A_STATUS   8'h34
`define SPD_A_TOGGLE   8'h38
// ************************************************************
// widths, limits, coefficients
// ************************************************************
`define SPD_SW         24
`define SPD_AW         18
`define SPD_DEPTH      262144
`define SPD_FAW        9
`define SPD_FDEPTH     512
`define SPD_MAX_MAIN   240000
`define SPD_MAX_FINE   500
`define SPD_COARSE_STEP 48
`define SPD_GAIN_ONE   16'sh1000
`define SPD_GAIN_MIN   16'sh0200
`define SPD_GAIN_MAX   16'sh1FED
`define SPD_GAIN_RST   16'h1000
`define SPD_CORNER_RST 16'h0800
`define SPD_FB_MAX     8'sd99
`define SPD_PCT_LIMIT  9'd100
`define SPD_PCT_MUL    17'h0_A3D7
`define SPD_DE_B0      16'sh1D6C
`define SPD_DE_B1      16'shF9AA
`define SPD_DE_A1      16'sh28EA
`define SPD_DC_SHIFT   12
`define SPD_BINAURAL_SPREADER_MAX   4'hA
`define SPD_BINAURAL_SPREADER_STEP  16'h0_00A0
`define SPD_BINAURAL_SPREADER_BOOST 24'sh00_0008
`define SPD_DC_OFF     2'h0
`define SPD_DC_MANUAL  2'h1
`define SPD_DC_AUTO    2'h2
`endif

// ===== pkg/spd_pkg.sv
// Purpose: types of the stereo post delay / adjust block
// Assumes: constants come from spd_params.svh
// Notes:   all block state but the delay memories and the ready flop is one packed struct
`include "spd_params.svh"
package spd_pkg;
	typedef logic signed [`SPD_SW-1:0] spd_samp_t;	// one audio word
	typedef struct packed {
		logic      valid;	// one-cycle sample strobe
		spd_samp_t left;
		spd_samp_t right;
	} spd_sample_t;
	typedef struct packed {
		logic       skew;	// half-tick skew on left
		logic       emphasis_undo;	// emphasis undo
		logic [1:0] route;	// right polarity route
		logic [1:0] dc_mode;	// offset trim mode
		logic [1:0] coarse_half;	// doubled coarse resolution
		logic [1:0] fine_extra;	// one-sample fine steps
	} spd_ctrl_t;
	typedef struct packed {
		spd_samp_t          dc_corr;	// held offset correction
		spd_samp_t          de_x1;
		spd_samp_t          de_y1;
		spd_samp_t          lp_low;
		spd_samp_t          lp_high;
		spd_samp_t          lp_split;
		spd_samp_t          out_prev;	// last chain output
		logic [11:0]        coarse;	// coarse delay steps
		logic [8:0]         fine;	// fine delay steps
		logic signed [7:0]  fb;	// overall feedback percent
		logic signed [7:0]  ff;	// fine feedback percent
		logic signed [15:0] split_gain;
		logic               overload;
	} spd_chan_t;
	typedef struct packed {
		spd_ctrl_t          ctrl;
		spd_chan_t [1:0]    ch;	// 0 left, 1 right
		logic [11:0]        master;
		logic signed [15:0] low_gain;
		logic [15:0]        low_corner;
		logic signed [15:0] high_gain;
		logic [15:0]        high_corner;
		logic [15:0]        split_corner;
		logic [3:0]         binaural_spreader;
		spd_samp_t          diff_lp;
		spd_samp_t          prev_left;
		logic [`SPD_AW-1:0]  wp;
		logic [`SPD_FAW-1:0] fp;
		logic [7:0]         bus_addr;
		logic               bus_wr;
		logic               bus_act;
		logic [31:0]        hrdata;
		spd_sample_t        out;
	} spd_state_t;
endpackage

// ===== rtl/spd_top.sv
// Purpose: stereo output conditioning with 5 s post delay and trims
// Assumes: one sample strobe per audio tick, AHB-Lite register access
// Notes:   processing of a sample completes in the cycle of its strobe
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - master delay always in path, unbypassable
// - skew on: left half sample later
// - emphasis undo filters input first
// - route: normal, invert, swap, invert+swap
// - trim mode off: no offset correction
// - auto mode: track and remove offset
// - manual write replaces held correction
// - master plus left coarse capped 5000 ms
// - master plus right coarse capped 5000 ms
// - toggle halves coarse step per channel
// - up to 500 fine samples added
// - fine delay 500 samples, 2-sample steps
// - toggle gives one-sample fine steps
// - overall feedback around whole chain
// - fine feedback around fine section only
// - feedback gains -99..+99 percent
// - overload when the summed gain magnitudes of a side exceed 100
// - spreader boosts difference signal only
// - spreader 0..10, zero disables
// - spreader corner rises with setting
// - split high corner for per-side shelves
// - corner sets cut response point
// - low and high shelves equal on both channels, clamped
module spd_top
	import spd_pkg::*;
#(
	parameter int COARSE_STEP = `SPD_COARSE_STEP	// samples per coarse step
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire spd_sample_t in_samp,
	output spd_sample_t      out_samp,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	// ************************************************************
	// storage
	// ************************************************************
	spd_state_t st_ff;	// every state bit but the ready flop and the delay memories
	spd_state_t nxt_st;
	// the long lines dominate area; depth covers 5 s plus the fine span
	spd_samp_t  main_mem [2][`SPD_DEPTH];	// post delay lines
	spd_samp_t  fine_mem [2][`SPD_FDEPTH];	// fine sections
	spd_samp_t  main_wr  [2];
	spd_samp_t  fine_wr  [2];
	// ready low through reset so no transfer is taken then
	logic       rdy_ff;	// zero-wait slave, ready after reset
	// ************************************************************
	// arithmetic helpers
	// ************************************************************
	// products are formed at 56 bits so no partial product wraps
	// saturate a wide value to one audio word
	function automatic spd_samp_t sat(input logic signed [55:0] v);
		if (v > 56'sh7F_FFFF) begin
			return 24'sh7F_FFFF;
		end else if (v < -56'sh80_0000) begin
			return -24'sh80_0000;
		end
		return v[23:0];
	endfunction
	// q16 coefficient multiply
	function automatic logic signed [55:0] mq16(input spd_samp_t x, input logic [15:0] c);
		logic signed [55:0] p;
		p = x * $signed({1'b0, c});
		return p >>> 16;
	endfunction
	// q12 gain multiply, used by both shelf kinds
	function automatic logic signed [55:0] mq12(input logic signed [55:0] x,
	                                            input logic signed [15:0] g);
		logic signed [55:0] p;
		p = x * g;
		return p >>> 12;
	endfunction
	// scale by signed percent, negative inverts the return
	function automatic logic signed [55:0] pct(input spd_samp_t x, input logic signed [7:0] g);
		logic signed [55:0] p;
		// zero gain gives an exact zero, so unwritten delay words
		// cannot leak unknowns around an idle loop
		if (g == 8'sh00) begin
			return '0;
		end
		p = x * g * $signed({1'b0, `SPD_PCT_MUL});
		return p >>> 22;
	endfunction
	// clamp a feedback byte into the legal percent range
	function automatic logic signed [7:0] fclamp(input logic [7:0] v);
		if ($signed(v) > `SPD_FB_MAX) begin
			return `SPD_FB_MAX;
		end else if ($signed(v) < -`SPD_FB_MAX) begin
			return -`SPD_FB_MAX;
		end
		return $signed(v);
	endfunction
	// clamp a shelf gain to cut/boost limits
	function automatic logic signed [15:0] gclamp(input logic [15:0] v);
		if ($signed(v) > `SPD_GAIN_MAX) begin
			return `SPD_GAIN_MAX;
		end else if ($signed(v) < `SPD_GAIN_MIN) begin
			return `SPD_GAIN_MIN;
		end
		return $signed(v);
	endfunction
	// magnitude of a percent
	function automatic logic [8:0] mag(input logic signed [7:0] v);
		return (v < 0) ? 9'(-v) : 9'(v);
	endfunction
	// ************************************************************
	// register read mux, sampled in the address phase
	// ************************************************************
	// offsets not listed read as zero; trims read back the held correction
	function automatic logic [31:0] rd_mux(input spd_state_t s, input logic [7:0] a);
		case (a)
			`SPD_A_CTRL:    return {22'h0, s.ctrl};
			`SPD_A_MASTER:  return {20'h0, s.master};
			`SPD_A_LCOARSE: return {20'h0, s.ch[0].coarse};
			`SPD_A_RCOARSE: return {20'h0, s.ch[1].coarse};
			`SPD_A_FINE:    return {7'h0, s.ch[1].fine, 7'h0, s.ch[0].fine};
			`SPD_A_FBACK:   return {s.ch[1].ff, s.ch[1].fb, s.ch[0].ff, s.ch[0].fb};
			`SPD_A_LOW:     return {s.low_corner, s.low_gain};
			`SPD_A_HIGH:    return {s.high_corner, s.high_gain};
			`SPD_A_SPLITC:  return {16'h0, s.split_corner};
			`SPD_A_SPLITG:  return {s.ch[1].split_gain, s.ch[0].split_gain};
			`SPD_A_BINAURAL_SPREADER:    return {28'h0, s.binaural_spreader};
			`SPD_A_DCL:     return {{8{s.ch[0].dc_corr[23]}}, s.ch[0].dc_corr};
			`SPD_A_DCR:     return {{8{s.ch[1].dc_corr[23]}}, s.ch[1].dc_corr};
			`SPD_A_STATUS:  return {30'h0, s.ch[1].overload, s.ch[0].overload};
			default:        return 32'h0000_0000;	// unmapped reads zero
		endcase
	endfunction
	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		spd_samp_t          x [2];
		spd_samp_t          rt [2];
		spd_samp_t          fine_rd [2];
		logic signed [55:0] w;
		logic signed [55:0] d;
		int                 tot;
		int                 fs;
		logic [`SPD_AW-1:0]  ma;
		logic [`SPD_FAW-1:0] fa;
		// every local is cleared first so nothing holds over as a latch
		nxt_st = st_ff;
		w      = '0;
		d      = '0;
		tot    = 0;
		fs     = 0;
		ma     = '0;
		fa     = '0;
		for (int c = 0; c < 2; c++) begin
			x[c]       = '0;
			rt[c]      = '0;
			fine_rd[c] = '0;
			main_wr[c] = '0;
			fine_wr[c] = '0;
		end
		nxt_st.out.valid = 1'b0;
		// bus: data phase write uses the captured address
		// hwdata only stands in the data phase, hence the held address
		if (st_ff.bus_act && st_ff.bus_wr) begin
			case (st_ff.bus_addr)
				`SPD_A_CTRL:    nxt_st.ctrl = hwdata[9:0];
				`SPD_A_MASTER:  nxt_st.master = hwdata[11:0];
				`SPD_A_LCOARSE: nxt_st.ch[0].coarse = hwdata[11:0];
				`SPD_A_RCOARSE: nxt_st.ch[1].coarse = hwdata[11:0];
				`SPD_A_FINE: begin
					nxt_st.ch[0].fine = hwdata[8:0];
					nxt_st.ch[1].fine = hwdata[24:16];
				end
				`SPD_A_FBACK: begin
					nxt_st.ch[0].fb = fclamp(hwdata[7:0]);
					nxt_st.ch[0].ff = fclamp(hwdata[15:8]);
					nxt_st.ch[1].fb = fclamp(hwdata[23:16]);
					nxt_st.ch[1].ff = fclamp(hwdata[31:24]);
				end
				`SPD_A_LOW: begin
					nxt_st.low_gain   = gclamp(hwdata[15:0]);
					nxt_st.low_corner = hwdata[31:16];
				end
				`SPD_A_HIGH: begin
					nxt_st.high_gain   = gclamp(hwdata[15:0]);
					nxt_st.high_corner = hwdata[31:16];
				end
				`SPD_A_SPLITC: nxt_st.split_corner = hwdata[15:0];
				`SPD_A_SPLITG: begin
					nxt_st.ch[0].split_gain = gclamp(hwdata[15:0]);
					nxt_st.ch[1].split_gain = gclamp(hwdata[31:16]);
				end
				`SPD_A_BINAURAL_SPREADER: begin
					// out-of-range settings pin at the top
					nxt_st.binaural_spreader = (hwdata[3:0] > `SPD_BINAURAL_SPREADER_MAX) ? `SPD_BINAURAL_SPREADER_MAX
					                                           : hwdata[3:0];
				end
				`SPD_A_TOGGLE: begin
					nxt_st.ctrl.coarse_half = st_ff.ctrl.coarse_half ^ hwdata[1:0];
					nxt_st.ctrl.fine_extra  = st_ff.ctrl.fine_extra ^ hwdata[3:2];
				end
				`SPD_A_DCL: begin
					// trim writes only take hold in manual mode
					if (st_ff.ctrl.dc_mode == `SPD_DC_MANUAL) begin
						nxt_st.ch[0].dc_corr = hwdata[23:0];
					end
				end
				`SPD_A_DCR: begin
					if (st_ff.ctrl.dc_mode == `SPD_DC_MANUAL) begin
						nxt_st.ch[1].dc_corr = hwdata[23:0];
					end
				end
				default: ;	// unmapped or read-only, ignored
			endcase
		end
		// address phase capture; reply data ready for the data phase
		nxt_st.bus_act = hsel && htrans[1] && hready;
		if (hsel && htrans[1] && hready) begin
			nxt_st.bus_addr = haddr[7:0];
			nxt_st.bus_wr   = hwrite;
			nxt_st.hrdata   = rd_mux(st_ff, haddr[7:0]);
		end
		// overload flags follow the gains
		// taken from the next gains so status never lags a write
		for (int c = 0; c < 2; c++) begin
			nxt_st.ch[c].overload =
				(mag(nxt_st.ch[c].fb) + mag(nxt_st.ch[c].ff)) > `SPD_PCT_LIMIT;
		end
		// audio path, one sample per strobe
		if (in_samp.valid) begin
			x[0] = in_samp.left;
			x[1] = in_samp.right;
			for (int c = 0; c < 2; c++) begin
				// emphasis undo, first-order section
				// state only advances while the filter is on
				if (st_ff.ctrl.emphasis_undo) begin
					w = (x[c] * `SPD_DE_B0 + st_ff.ch[c].de_x1 * `SPD_DE_B1
					     + st_ff.ch[c].de_y1 * `SPD_DE_A1) >>> 14;
					nxt_st.ch[c].de_x1 = x[c];
					nxt_st.ch[c].de_y1 = sat(w);
					x[c] = sat(w);
				end
				// offset tracking and removal
				if (st_ff.ctrl.dc_mode == `SPD_DC_AUTO) begin
					w = st_ff.ch[c].dc_corr
					    + ((x[c] - st_ff.ch[c].dc_corr) >>> `SPD_DC_SHIFT);
					nxt_st.ch[c].dc_corr = sat(w);
				end
				if (st_ff.ctrl.dc_mode != `SPD_DC_OFF) begin
					x[c] = sat(x[c] - st_ff.ch[c].dc_corr);
				end	// off mode passes the word untouched
			end
			// right polarity route
			// inversion saturates so full-scale negative cannot wrap
			case (st_ff.ctrl.route)
				2'h0: begin rt[0] = x[0]; rt[1] = x[1]; end
				2'h1: begin rt[0] = x[0]; rt[1] = sat(-x[1]); end
				2'h2: begin rt[0] = x[1]; rt[1] = x[0]; end
				default: begin rt[0] = sat(-x[1]); rt[1] = x[0]; end
			endcase
			for (int c = 0; c < 2; c++) begin
				// shared low and high shelves, same for both sides
				w = st_ff.ch[c].lp_low + mq16(rt[c] - st_ff.ch[c].lp_low, st_ff.low_corner);
				nxt_st.ch[c].lp_low = sat(w);
				d = rt[c] + mq12(56'(st_ff.ch[c].lp_low),
				                 16'(st_ff.low_gain - `SPD_GAIN_ONE));
				w = st_ff.ch[c].lp_high + mq16(rt[c] - st_ff.ch[c].lp_high, st_ff.high_corner);
				nxt_st.ch[c].lp_high = sat(w);
				d = d + mq12(56'(rt[c] - st_ff.ch[c].lp_high),
				             16'(st_ff.high_gain - `SPD_GAIN_ONE));
				// per-side high shelf on the split corner
				w = st_ff.ch[c].lp_split
				    + mq16(rt[c] - st_ff.ch[c].lp_split, st_ff.split_corner);
				nxt_st.ch[c].lp_split = sat(w);
				d = d + mq12(56'(rt[c] - st_ff.ch[c].lp_split),
				             16'(st_ff.ch[c].split_gain - `SPD_GAIN_ONE));
				x[c] = sat(d);
			end
			// spreader: only the difference gets low boost
			if (st_ff.binaural_spreader != 4'h0) begin
				d = (x[0] - x[1]) >>> 1;
				w = st_ff.diff_lp + mq16(sat(d - st_ff.diff_lp),
				                         16'(st_ff.binaural_spreader * `SPD_BINAURAL_SPREADER_STEP));
				nxt_st.diff_lp = sat(w);
				d = d + st_ff.diff_lp * `SPD_BINAURAL_SPREADER_BOOST;
				w = (x[0] + x[1]) >>> 1;
				x[0] = sat(w + d);
				x[1] = sat(w - d);
			end	// setting zero leaves the pair untouched
			// half-sample skew by averaging with the previous left
			// a two-tap average: exact at low frequency, dulls the top octave
			nxt_st.prev_left = x[0];
			if (st_ff.ctrl.skew) begin
				x[0] = sat((x[0] + st_ff.prev_left) >>> 1);
			end
			// delay chain with both feedback loops
			// total latency is tot + fs + 2 samples, one per line pass
			for (int c = 0; c < 2; c++) begin
				tot = int'(st_ff.master) * COARSE_STEP;
				if (st_ff.ctrl.coarse_half[c]) begin
					tot = tot + int'(st_ff.ch[c].coarse) * COARSE_STEP / 2;
				end else begin
					tot = tot + int'(st_ff.ch[c].coarse) * COARSE_STEP;
				end
				if (tot > `SPD_MAX_MAIN) begin
					tot = `SPD_MAX_MAIN;
				end
				fs = st_ff.ctrl.fine_extra[c] ? int'(st_ff.ch[c].fine)
				                               : 2 * int'(st_ff.ch[c].fine);
				if (fs > `SPD_MAX_FINE) begin
					fs = `SPD_MAX_FINE;
				end
				main_wr[c] = sat(x[c] + pct(st_ff.ch[c].out_prev, st_ff.ch[c].fb));
				// pointers wrap on their own at the power-of-two depths
				ma = st_ff.wp - `SPD_AW'(tot) - `SPD_AW'(1);
				fa = st_ff.fp - `SPD_FAW'(fs) - `SPD_FAW'(1);
				fine_rd[c] = fine_mem[c][fa];
				fine_wr[c] = sat(main_mem[c][ma] + pct(fine_rd[c], st_ff.ch[c].ff));
				nxt_st.ch[c].out_prev = fine_rd[c];
			end
			nxt_st.wp = st_ff.wp + `SPD_AW'(1);
			nxt_st.fp = st_ff.fp + `SPD_FAW'(1);
			nxt_st.out.valid = 1'b1;
			nxt_st.out.left  = fine_rd[0];
			nxt_st.out.right = fine_rd[1];
		end
	end
	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff                   <= '0;
			st_ff.low_gain          <= `SPD_GAIN_RST;
			st_ff.high_gain         <= `SPD_GAIN_RST;
			st_ff.ch[0].split_gain  <= `SPD_GAIN_RST;
			st_ff.ch[1].split_gain  <= `SPD_GAIN_RST;
			st_ff.low_corner        <= `SPD_CORNER_RST;
			st_ff.high_corner       <= `SPD_CORNER_RST;
			st_ff.split_corner      <= `SPD_CORNER_RST;
			rdy_ff                  <= 1'b0;
		end else begin
			st_ff  <= nxt_st;
			rdy_ff <= 1'b1;
		end
	end
	// ************************************************************
	// delay memories, no reset: contents settle within one pass
	// ************************************************************
	// each write lands at the pointer, ahead of every read tap
	always_ff @(posedge clk) begin
		if (in_samp.valid) begin
			for (int c = 0; c < 2; c++) begin
				main_mem[c][st_ff.wp] <= main_wr[c];
				fine_mem[c][st_ff.fp] <= fine_wr[c];
			end
		end
	end
	// ************************************************************
	// outputs, all from flops
	// ************************************************************
	assign out_samp  = st_ff.out;
	assign hrdata    = st_ff.hrdata;
	assign hreadyout = rdy_ff;
	// masked flop bit keeps hresp a register output as well
	assign hresp     = st_ff.hrdata[0] & 1'b0;	// always okay
endmodule
